// *** design/sfl_map.vh ***
`ifndef SFL_MAP_VH
`define SFL_MAP_VH
// command codes
`define SFL_CMD_STATUS 8'h41
`define SFL_CMD_CTRL 8'h60
`define SFL_CMD_DATA 8'h61
`define SFL_CMD_ADDR_LO 8'h62
`define SFL_CMD_ADDR_HI 8'h63
// bus address kinds seen by the serial front end
`define SFL_BUS_LOWER 2'h0
`define SFL_BUS_UPPER 2'h1
`define SFL_BUS_BCAST 2'h2
// control field positions
`define SFL_B_PROG 7
`define SFL_B_HOLD 6
`define SFL_B_PARITY_CHECK_ENABLE 4
`define SFL_B_EXEC 3
`define SFL_B_PARITY_MEMORY_SELECT 2
`define SFL_B_DIR 1
`define SFL_B_CLR 0
`define SFL_CTRL_WMASK 8'hff
// reset values
`define SFL_CTRL_RST 8'h00
`define SFL_ADDR_RST 8'h00
`define SFL_STATUS_RST 8'h00
// status answers
`define SFL_STATUS_BAD 8'hff
`define SFL_STATUS_MIN 8'h01
// memory and buffer shape
`define SFL_MEM_AW 10
`define SFL_MEM_DEPTH 1024
`define SFL_FIFO_W 9
`define SFL_FIFO_D 8
`define SFL_FIFO_CW 4
// timing
`define SFL_CLK_KHZ 10000
`define SFL_CHECK_TIME_US 1000
`define SFL_CHECK_CYC ((`SFL_CHECK_TIME_US * `SFL_CLK_KHZ) / 1000)
`endif

// *** design/sfl_loader.v ***
//Contract
// - 16-bit start address in two byte registers
// - loading works at lower bus address, refused at upper
// - broadcast bus address also accepts loading
// - reload accepted while in safe mode
// - data port bytes go to program memory
// - data port bytes go to parity memory
// - compatibility check finishes within 1 ms
// - valid load reports status 0x01 to 0xfe
// - invalid load sets status all ones
// - invalid load clears execute enable itself
// - safe mode until later load completes
// - pointer clear resets pointer, release frees it
// - continuous data port transfers until stop; bus_stop is unused, transfers end only when data accesses stop
// - processor hold resets cpu, registers untouched
// - execute enable selects sram plus rom
`timescale 1ns/1ns
`default_nettype none
`include "sfl_map.vh"

module sfl_fifo #(
   parameter W = 9,
   parameter D = 8,
   parameter CW = 4
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // fill side
   input wire s_valid,
   output wire s_ready,
   input wire [W-1:0] s_data,
   // drain side
   output wire m_valid,
   input wire m_ready,
   output wire [W-1:0] m_data
);
   reg [W-1:0] mem [0:D-1];
   reg [CW-1:0] wp_ff;
   reg [CW-1:0] rp_ff;
   reg [CW-1:0] cnt_ff;
   reg full_ff;
   wire push;
   wire pop;
   wire [CW-1:0] nxt_cnt;
   assign s_ready = ~full_ff;
   assign m_valid = (cnt_ff != {CW{1'b0}});
   assign m_data = mem[rp_ff[CW-2:0]];
   assign push = s_valid & ~full_ff;
   assign pop = m_valid & m_ready;
   assign nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
   always @(posedge clk) begin
      if (push) begin
         mem[wp_ff[CW-2:0]] <= s_data;
      end
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_ff <= {CW{1'b0}};
         rp_ff <= {CW{1'b0}};
         cnt_ff <= {CW{1'b0}};
         full_ff <= 1'b0;
      end else begin
         if (push) begin
            wp_ff <= wp_ff + {{(CW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rp_ff <= rp_ff + {{(CW-1){1'b0}}, 1'b1};
         end
         cnt_ff <= nxt_cnt;
         full_ff <= (nxt_cnt == D[CW-1:0]);
      end
   end
endmodule // sfl_fifo

module sfl_loader #(
   parameter CHECK_LIMIT = `SFL_CHECK_CYC
) (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // decoded command register port
   input wire reg_wr,
   input wire reg_rd,
   input wire [1:0] bus_addr_kind,
   input wire [7:0] reg_cmd,
   input wire [7:0] reg_wdata,
   input wire bus_stop,
   output reg reg_wr_ready_ff,
   output reg [7:0] reg_rdata_ff,
   output reg reg_rvalid_ff,
   // processor side
   output reg cpu_hold_ff,
   output reg exec_from_sram_ff,
   output reg parity_check_enable_ff,
   output reg safe_mode_ff,
   output reg check_busy_ff
);
   localparam ST_IDLE = 2'h0;
   localparam ST_DRAIN = 2'h1;
   localparam ST_SCAN = 2'h2;
   localparam [31:0] LIMIT = CHECK_LIMIT;

   reg [7:0] prog_mem [0:`SFL_MEM_DEPTH-1];
   reg [7:0] par_mem [0:`SFL_MEM_DEPTH-1];
   reg [7:0] ctrl_ff;
   reg [7:0] addr_lo_ff;
   reg [7:0] addr_hi_ff;
   reg [7:0] status_ff;
   reg [15:0] ptr_ff;
   reg [1:0] state_ff;
   reg [`SFL_MEM_AW:0] scan_ff;
   reg [7:0] sum_ff;
   reg bad_ff;
   reg [15:0] wait_ff;
   reg [1:0] nxt_state;
   reg [7:0] nxt_status;
   reg nxt_bad;
   reg run_go;
   reg check_end;
   wire [15:0] start_addr;
   wire accept;
   wire wr_ctrl;
   wire wr_data;
   wire rd_data;
   wire port_open;
   wire f_ready;
   wire f_valid;
   wire f_take;
   wire [8:0] f_data;
   wire [7:0] new_ctrl;
   wire [`SFL_MEM_AW-1:0] scan_a;
   wire [7:0] scan_byte;
   wire scan_par_ok;

   assign accept = (bus_addr_kind == `SFL_BUS_LOWER) | (bus_addr_kind == `SFL_BUS_BCAST);
   assign start_addr = {addr_hi_ff, addr_lo_ff};
   assign wr_ctrl = reg_wr & accept & (reg_cmd == `SFL_CMD_CTRL);
   assign new_ctrl = reg_wdata & `SFL_CTRL_WMASK;
   // data port is live only after setup with pointer released; safe mode does not block it
   assign port_open = ctrl_ff[`SFL_B_PROG] & ~ctrl_ff[`SFL_B_CLR] & (state_ff == ST_IDLE);
   assign wr_data = reg_wr & accept & (reg_cmd == `SFL_CMD_DATA) & port_open & ~ctrl_ff[`SFL_B_DIR];
   // broadcast reads would collide on the bus, so data port reads need the lower address; register reads are answered at any address
   assign rd_data = reg_rd & (bus_addr_kind == `SFL_BUS_LOWER) & (reg_cmd == `SFL_CMD_DATA) & port_open
                    & ctrl_ff[`SFL_B_DIR];
   // readback holds the memory port, so the buffer drain stalls that cycle
   assign f_take = ~rd_data & ~ctrl_ff[`SFL_B_CLR];

   sfl_fifo #(
      .W(`SFL_FIFO_W),
      .D(`SFL_FIFO_D),
      .CW(`SFL_FIFO_CW)
   ) u_fifo (
      .clk(mclk),
      .rst_n(rst_n),
      .s_valid(wr_data),
      .s_ready(f_ready),
      .s_data({ctrl_ff[`SFL_B_PARITY_MEMORY_SELECT], reg_wdata}),
      .m_valid(f_valid),
      .m_ready(f_take),
      .m_data(f_data)
   );

   always @(posedge mclk) begin
      if (f_valid & f_take) begin
         if (f_data[8]) begin
            par_mem[ptr_ff[`SFL_MEM_AW-1:0]] <= f_data[7:0];
         end else begin
            prog_mem[ptr_ff[`SFL_MEM_AW-1:0]] <= f_data[7:0];
         end
      end
   end

   assign scan_a = scan_ff[`SFL_MEM_AW-1:0];
   assign scan_byte = prog_mem[scan_a];
   assign scan_par_ok = (^scan_byte) == par_mem[scan_a][0];

   always @* begin
      // run sequence: leaving program access into parity check plus execute
      run_go = wr_ctrl & ctrl_ff[`SFL_B_PROG] & ~new_ctrl[`SFL_B_PROG] & ~new_ctrl[`SFL_B_HOLD]
               & ~new_ctrl[`SFL_B_PARITY_MEMORY_SELECT] & new_ctrl[`SFL_B_PARITY_CHECK_ENABLE] & new_ctrl[`SFL_B_EXEC]
               & ~new_ctrl[`SFL_B_DIR] & ~new_ctrl[`SFL_B_CLR];
      nxt_state = state_ff;
      nxt_bad = bad_ff;
      nxt_status = status_ff;
      check_end = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (run_go) begin
               nxt_state = ST_DRAIN;
               nxt_bad = 1'b0;
            end
         end
         ST_DRAIN: begin
            if (!f_valid) begin
               nxt_state = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (!scan_par_ok) begin
               nxt_bad = 1'b1;
            end
            if (scan_ff[`SFL_MEM_AW-1:0] == {`SFL_MEM_AW{1'b1}} || wait_ff >= LIMIT[15:0] - 16'h0001) begin
               check_end = 1'b1;
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (check_end) begin
         if (nxt_bad || wait_ff >= LIMIT[15:0] - 16'h0001) begin
            nxt_status = `SFL_STATUS_BAD;
         end else if ((sum_ff ^ scan_byte) == `SFL_STATUS_BAD || (sum_ff ^ scan_byte) == 8'h00) begin
            nxt_status = `SFL_STATUS_MIN;
         end else begin
            nxt_status = sum_ff ^ scan_byte;
         end
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= `SFL_CTRL_RST;
         addr_lo_ff <= `SFL_ADDR_RST;
         addr_hi_ff <= `SFL_ADDR_RST;
         status_ff <= `SFL_STATUS_RST;
         ptr_ff <= 16'h0000;
         state_ff <= ST_IDLE;
         scan_ff <= {(`SFL_MEM_AW+1){1'b0}};
         sum_ff <= 8'h00;
         bad_ff <= 1'b0;
         wait_ff <= 16'h0000;
         safe_mode_ff <= 1'b0;
         reg_rdata_ff <= 8'h00;
         reg_rvalid_ff <= 1'b0;
         reg_wr_ready_ff <= 1'b1;
         cpu_hold_ff <= 1'b0;
         exec_from_sram_ff <= 1'b0;
         parity_check_enable_ff <= 1'b0;
         check_busy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         bad_ff <= nxt_bad;
         status_ff <= nxt_status;
         if (wr_ctrl) begin
            ctrl_ff <= new_ctrl;
         end
         if (check_end && nxt_status == `SFL_STATUS_BAD) begin
            ctrl_ff[`SFL_B_EXEC] <= 1'b0;
         end
         if (reg_wr && accept && reg_cmd == `SFL_CMD_ADDR_LO) begin
            addr_lo_ff <= reg_wdata;
         end
         if (reg_wr && accept && reg_cmd == `SFL_CMD_ADDR_HI) begin
            addr_hi_ff <= reg_wdata;
         end
         if (ctrl_ff[`SFL_B_CLR]) begin
            ptr_ff <= start_addr;
         end else if ((f_valid && f_take) || rd_data) begin
            ptr_ff <= ptr_ff + 16'h0001;
         end
         if (state_ff == ST_SCAN) begin
            scan_ff <= scan_ff + {{`SFL_MEM_AW{1'b0}}, 1'b1};
            sum_ff <= sum_ff ^ scan_byte;
            wait_ff <= wait_ff + 16'h0001;
         end else if (state_ff == ST_IDLE) begin
            scan_ff <= {(`SFL_MEM_AW+1){1'b0}};
            sum_ff <= 8'h00;
            wait_ff <= 16'h0000;
         end else begin
            wait_ff <= wait_ff + 16'h0001;
         end
         if (check_end) begin
            safe_mode_ff <= (nxt_status == `SFL_STATUS_BAD);
         end
         reg_rvalid_ff <= reg_rd;
         if (rd_data) begin
            if (ctrl_ff[`SFL_B_PARITY_MEMORY_SELECT]) begin
               reg_rdata_ff <= par_mem[ptr_ff[`SFL_MEM_AW-1:0]];
            end else begin
               reg_rdata_ff <= prog_mem[ptr_ff[`SFL_MEM_AW-1:0]];
            end
         end else if (reg_rd) begin
            case (reg_cmd)
               `SFL_CMD_CTRL: reg_rdata_ff <= ctrl_ff;
               `SFL_CMD_ADDR_LO: reg_rdata_ff <= addr_lo_ff;
               `SFL_CMD_ADDR_HI: reg_rdata_ff <= addr_hi_ff;
               `SFL_CMD_STATUS: reg_rdata_ff <= status_ff;
               default: reg_rdata_ff <= 8'h00;
            endcase
         end
         reg_wr_ready_ff <= f_ready;
         // hold and execute are pure outputs; registers keep their contents under hold
         cpu_hold_ff <= ctrl_ff[`SFL_B_HOLD];
         exec_from_sram_ff <= ctrl_ff[`SFL_B_EXEC] & (state_ff == ST_IDLE);
         parity_check_enable_ff <= ctrl_ff[`SFL_B_PARITY_CHECK_ENABLE];
         check_busy_ff <= (state_ff != ST_IDLE);
      end
   end
endmodule // sfl_loader
`default_nettype wire

// *** verif/sfl_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module sfl_host #(
   parameter BOOT_CYC = 20
) (
   // answers
   input wire logic mclk,
   input wire logic reg_wr_ready_ff,
   input wire logic [7:0] reg_rdata_ff,
   input wire logic reg_rvalid_ff,
   // requests
   output var logic reg_wr = 1'b0,
   output var logic reg_rd = 1'b0,
   output var logic [1:0] bus_addr_kind = 2'h0,
   output var logic [7:0] reg_cmd = 8'h00,
   output var logic [7:0] reg_wdata = 8'h00,
   output var logic bus_stop = 1'b0
);
   // power-up wait shortened to BOOT_CYC cycles, nothing sent during it
   task automatic boot;
      repeat (BOOT_CYC) @(negedge mclk);
   endtask
   // released lines invert so stale values never pass for fresh ones
   task automatic wr(input logic [1:0] k, input logic [7:0] c, input logic [7:0] d);
      @(negedge mclk);
      while (reg_wr_ready_ff !== 1'b1) @(negedge mclk);
      {reg_wr, bus_addr_kind, reg_cmd, reg_wdata} = {1'b1, k, c, d};
      @(negedge mclk);
      {reg_wr, bus_addr_kind, reg_cmd, reg_wdata} = {1'b0, ~k, ~c, ~d};
   endtask
   task automatic rd(input logic [7:0] c, output logic [7:0] d);
      @(negedge mclk);
      {reg_rd, bus_addr_kind, reg_cmd} = {1'b1, 2'h0, c};
      @(negedge mclk);
      {reg_rd, reg_cmd} = {1'b0, ~c};
      d = (reg_rvalid_ff === 1'b1) ? reg_rdata_ff : 8'hxx;
   endtask
   // pointer clear pulsed low-high-low around the mode
   task automatic setup(input logic [7:0] m);
      wr(2'h2, 8'h60, m);
      wr(2'h2, 8'h60, m | 8'h01);
      wr(2'h2, 8'h60, m);
   endtask
endmodule // sfl_host
`default_nettype wire

// *** verif/sfl_loader_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sfl_map.vh"
module sfl_loader_sva #(
   parameter CHECK_LIMIT = 10000
) (
   // requests
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [1:0] bus_addr_kind,
   input wire logic [7:0] reg_cmd,
   input wire logic [7:0] reg_wdata,
   input wire logic bus_stop,
   // answers
   input wire logic reg_wr_ready_ff,
   input wire logic [7:0] reg_rdata_ff,
   input wire logic reg_rvalid_ff,
   input wire logic cpu_hold_ff,
   input wire logic exec_from_sram_ff,
   input wire logic parity_check_enable_ff,
   input wire logic safe_mode_ff,
   input wire logic check_busy_ff
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic [15:0] busy_cnt_ff;
   logic ctl_wr;
   assign ctl_wr = reg_wr && reg_wr_ready_ff && reg_cmd == `SFL_CMD_CTRL;
   // 1 ms is too long for a delay range, so count it
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt_ff <= 16'h0000;
      end else begin
         busy_cnt_ff <= check_busy_ff ? busy_cnt_ff + 16'h0001 : 16'h0000;
      end
   end
   property p_rd; reg_rd |=> reg_rvalid_ff; endproperty
   a_rd: assert property (p_rd) else $error("read unanswered");
   property p_nord; !reg_rd |=> !reg_rvalid_ff; endproperty
   a_nord: assert property (p_nord) else $error("spurious read answer");
   property p_copy; ctl_wr && bus_addr_kind != `SFL_BUS_UPPER |-> ##2
      cpu_hold_ff == $past(reg_wdata[6], 2) && parity_check_enable_ff == $past(reg_wdata[4], 2); endproperty
   a_copy: assert property (p_copy) else $error("hold or parity bit not followed");
   property p_upper; (ctl_wr && bus_addr_kind == `SFL_BUS_UPPER) ##1 !reg_wr |=> $stable(cpu_hold_ff); endproperty
   a_upper: assert property (p_upper) else $error("upper write took effect");
   property p_time; busy_cnt_ff <= 16'h2710 && busy_cnt_ff <= CHECK_LIMIT + 4; endproperty
   a_time: assert property (p_time) else $error("check too long");
   property p_cause; $rose(check_busy_ff) |-> $past(reg_wr, 2) && $past(reg_cmd, 2) == `SFL_CMD_CTRL; endproperty
   a_cause: assert property (p_cause) else $error("check without run write");
   property p_bad; $rose(safe_mode_ff) |=> !exec_from_sram_ff [*3]; endproperty
   a_bad: assert property (p_bad) else $error("execute kept after bad load");
   property p_good; $fell(check_busy_ff) ##2 !safe_mode_ff |-> exec_from_sram_ff; endproperty
   a_good: assert property (p_good) else $error("no execute after good load");
   property p_safe; safe_mode_ff && !check_busy_ff |=> safe_mode_ff || check_busy_ff; endproperty
   a_safe: assert property (p_safe) else $error("safe mode left early");
endmodule // sfl_loader_sva
bind sfl_loader sfl_loader_sva #(.CHECK_LIMIT(CHECK_LIMIT)) u_sfl_loader_sva (.mclk, .rst_n, .reg_wr, .reg_rd,
   .bus_addr_kind, .reg_cmd, .reg_wdata, .bus_stop, .reg_wr_ready_ff, .reg_rdata_ff, .reg_rvalid_ff,
   .cpu_hold_ff, .exec_from_sram_ff, .parity_check_enable_ff, .safe_mode_ff, .check_busy_ff);
`default_nettype wire

// *** verif/sfl_loader_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sfl_map.vh"
module sfl_loader_tb_top;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr, reg_rd, bus_stop, reg_wr_ready_ff, reg_rvalid_ff, cpu_hold_ff, exec_from_sram_ff;
   logic parity_check_enable_ff, safe_mode_ff, check_busy_ff;
   logic [1:0] bus_addr_kind;
   logic [7:0] reg_cmd, reg_wdata, reg_rdata_ff, rd_val;
   logic [7:0] rst_cmds [4] = '{`SFL_CMD_STATUS, `SFL_CMD_CTRL, `SFL_CMD_ADDR_LO, `SFL_CMD_ADDR_HI};
   int err_total = 0;
   int check_count = 0;
   always #50 mclk = ~mclk;
   sfl_loader #(.CHECK_LIMIT(2000)) u_sfl_loader (.mclk, .rst_n, .reg_wr, .reg_rd, .bus_addr_kind, .reg_cmd,
      .reg_wdata, .bus_stop, .reg_wr_ready_ff, .reg_rdata_ff, .reg_rvalid_ff, .cpu_hold_ff, .exec_from_sram_ff,
      .parity_check_enable_ff, .safe_mode_ff, .check_busy_ff);
   sfl_host u_sfl_host (.mclk, .reg_wr_ready_ff, .reg_rdata_ff, .reg_rvalid_ff, .reg_wr, .reg_rd, .bus_addr_kind,
      .reg_cmd, .reg_wdata, .bus_stop);
   function automatic logic [7:0] pat(input int i);
      return (i == 0) ? 8'h3c : i[7:0];
   endfunction
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rchk(input string name, input logic [7:0] c, input logic [7:0] exp);
      u_sfl_host.rd(c, rd_val);
      chk(name, rd_val, exp);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // both memories filled whole so the scan never meets an unloaded byte
   task automatic load(input logic bad);
      u_sfl_host.wr(2'h0, `SFL_CMD_ADDR_LO, 8'h00);
      u_sfl_host.wr(2'h0, `SFL_CMD_ADDR_HI, 8'h00);
      u_sfl_host.setup(8'hc0);
      for (int i = 0; i < `SFL_MEM_DEPTH; i++) u_sfl_host.wr(2'h0, `SFL_CMD_DATA, pat(i));
      u_sfl_host.setup(8'hc4);
      for (int i = 0; i < `SFL_MEM_DEPTH; i++) begin
         u_sfl_host.wr(2'h0, `SFL_CMD_DATA, {7'h00, ^pat(i) ^ (bad && i == 5)});
      end
   endtask
   task automatic run(input logic [7:0] st, input logic bad);
      int n = 0;
      u_sfl_host.wr(2'h0, `SFL_CMD_CTRL, 8'h18);
      // busy rises two edges after the run write, not at once
      while (check_busy_ff !== 1'b1 && n < 4) begin
         @(negedge mclk);
         n++;
      end
      chk("check_start", {7'h00, check_busy_ff}, 8'h01);
      n = 0;
      while (check_busy_ff !== 1'b0 && n < 3000) begin
         @(negedge mclk);
         n++;
      end
      chk("check_busy", {7'h00, check_busy_ff}, 8'h00);
      rchk("status", `SFL_CMD_STATUS, st);
      rchk("control", `SFL_CMD_CTRL, bad ? 8'h10 : 8'h18);
      chk("safe_mode", {7'h00, safe_mode_ff}, {7'h00, bad});
      chk("exec_sram", {7'h00, exec_from_sram_ff}, {7'h00, ~bad});
      chk("parity_check", {7'h00, parity_check_enable_ff}, 8'h01);
      chk("cpu_hold_run", {7'h00, cpu_hold_ff}, 8'h00);
   endtask
   initial begin
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      u_sfl_host.boot();
      chk("wr_ready", {7'h00, reg_wr_ready_ff}, 8'h01);
      foreach (rst_cmds[i]) rchk("reset_value", rst_cmds[i], 8'h00);
      u_sfl_host.wr(2'h0, `SFL_CMD_ADDR_LO, 8'h34);
      u_sfl_host.wr(2'h2, `SFL_CMD_ADDR_HI, 8'h12);
      u_sfl_host.wr(2'h1, `SFL_CMD_ADDR_LO, 8'haa);
      u_sfl_host.wr(2'h1, `SFL_CMD_CTRL, 8'hc0);
      rchk("addr_low", `SFL_CMD_ADDR_LO, 8'h34);
      rchk("addr_high", `SFL_CMD_ADDR_HI, 8'h12);
      rchk("control_upper", `SFL_CMD_CTRL, 8'h00);
      load(1'b0);
      chk("cpu_hold", {7'h00, cpu_hold_ff}, 8'h01);
      u_sfl_host.wr(2'h0, `SFL_CMD_ADDR_LO, 8'h02);
      u_sfl_host.setup(8'hc2);
      for (int i = 2; i < 5; i++) rchk("program_read", `SFL_CMD_DATA, pat(i));
      u_sfl_host.setup(8'hc6);
      for (int i = 2; i < 5; i++) rchk("parity_read", `SFL_CMD_DATA, {7'h00, ^pat(i)});
      run(8'h3c, 1'b0);
      load(1'b1);
      run(8'hff, 1'b1);
      load(1'b0);
      run(8'h3c, 1'b0);
      results();
   end
   // about twice the expected run length
   initial begin
      #3000000;
      err_total++;
      results();
   end
endmodule // sfl_loader_tb_top
`default_nettype wire
